// [hw/cat_timebase.sv]
// Time base, run control and flag core of the five-module counter_array.
// Assumes the modules, timer 0 and the CPU idle state are outside and synchronous.
//
// Our own choice: strobed register access.
`default_nettype none

module cat_timebase
   import cat_pkg::*;
(
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_rstn,
   // Register bus
   input wire cat_bus_t i_bus,
   output logic [7:0] o_rdata,
   // System inputs
   input wire logic i_double_speed_mode,
   input wire logic i_cpu_idle,
   input wire logic i_timer0_ovf,
   input wire logic i_ext_count_input,
   // Module side
   input wire logic [4:0] i_module_event,
   input wire logic [4:0] i_module_irq_en,
   input wire logic [4:0] i_module_pin_used,
   output logic [15:0] o_count_value,
   output logic o_rollover,
   output logic o_module4_watchdog_en,
   output logic [7:0] o_port1_claim,
   // Interrupts
   output logic o_vector_irq,
   output logic o_irq
);

   logic [7:0] ctrl_q;
   logic [7:0] mode_q;
   logic [7:0] stat_q;
   logic [7:0] mask_q;
   logic [15:0] cnt_q;
   logic [3:0] psc_q;
   logic [3:0] div;
   logic psc_tick;
   logic ext_s1_q;
   logic ext_s2_q;
   logic ext_s3_q;
   logic ext_pulse;
   logic count_pulse;
   logic count_en;
   logic step;
   logic rollover;
   logic wr_ctrl;
   logic wr_mode;
   logic wr_stat;
   logic wr_mask;
   logic [7:0] rdata_q;
   logic [7:0] rd_mux;
   logic [7:0] hw_events;
   cat_src_t src;

   // Decoded mode fields and register write strobes
   assign src = cat_src_t'(mode_q[CAT_MODE_SRC_HI:CAT_MODE_SRC_LO]);
   assign wr_ctrl = i_bus.wr && (i_bus.addr == CAT_ADDR_CTRL);
   assign wr_mode = i_bus.wr && (i_bus.addr == CAT_ADDR_MODE);
   assign wr_stat = i_bus.wr && (i_bus.addr == CAT_ADDR_IRQ_STAT);
   assign wr_mask = i_bus.wr && (i_bus.addr == CAT_ADDR_IRQ_MASK);

   // Oscillator prescaler, restarts safely if the ratio shrinks
   assign div = cat_div(src, i_double_speed_mode);
   assign psc_tick = (psc_q >= div - 4'h1);

   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         psc_q <= 4'h0;
      end else if (psc_tick) begin
         psc_q <= 4'h0;
      end else begin
         psc_q <= psc_q + 4'h1;
      end
   end

   // External count input synchroniser and falling-edge detect
   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         ext_s1_q <= 1'b0;
         ext_s2_q <= 1'b0;
         ext_s3_q <= 1'b0;
      end else begin
         ext_s1_q <= i_ext_count_input;
         ext_s2_q <= ext_s1_q;
         ext_s3_q <= ext_s2_q;
      end
   end

   assign ext_pulse = ext_s3_q && !ext_s2_q;

   // Count source selection
   always_comb begin
      unique case (src)
         CAT_SRC_SLOW: count_pulse = psc_tick;
         CAT_SRC_FAST: count_pulse = psc_tick;
         CAT_SRC_T0: count_pulse = i_timer0_ovf;
         CAT_SRC_EXT: count_pulse = ext_pulse;
      endcase
   end

   // Run and idle gating
   assign count_en = ctrl_q[CAT_CTRL_RUN_BIT]
      && !(mode_q[CAT_MODE_IDLE_BIT] && i_cpu_idle);
   assign step = count_en && count_pulse;
   assign rollover = step && (cnt_q == CAT_CNT_MAX);

   // Shared 16-bit time base
   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         cnt_q <= CAT_CNT_RST;
      end else if (step) begin
         cnt_q <= cnt_q + 16'h0001;
      end
   end

   // Control register: run bit, overflow flag, module flags; set beats clear
   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         ctrl_q <= CAT_CTRL_RST;
      end else begin
         if (wr_ctrl) begin
            ctrl_q <= i_bus.wdata & CAT_CTRL_MASK;
         end
         if (rollover) begin
            ctrl_q[CAT_CTRL_OVF_BIT] <= 1'b1;
         end
         for (int i = 0; i < CAT_NUM_MODULES; i++) begin
            if (i_module_event[i]) begin
               ctrl_q[i] <= 1'b1;
            end
         end
      end
   end

   // Mode register
   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         mode_q <= CAT_MODE_RST;
      end else if (wr_mode) begin
         mode_q <= i_bus.wdata & CAT_MODE_MASK;
      end
   end

   // Sticky event status, write one to clear, events win
   assign hw_events = {rollover, 2'b00, i_module_event};

   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         stat_q <= 8'h00;
         mask_q <= 8'h00;
      end else begin
         stat_q <= ((wr_stat ? stat_q & ~i_bus.wdata : stat_q) | hw_events) & CAT_IRQ_BITS;
         if (wr_mask) begin
            mask_q <= i_bus.wdata & CAT_IRQ_BITS;
         end
      end
   end

   // Read decode, unmapped and reserved bits read zero
   always_comb begin
      unique case (i_bus.addr)
         CAT_ADDR_CTRL: rd_mux = ctrl_q;
         CAT_ADDR_MODE: rd_mux = mode_q;
         CAT_ADDR_CNT_LO: rd_mux = cnt_q[7:0];
         CAT_ADDR_CNT_HI: rd_mux = cnt_q[15:8];
         CAT_ADDR_IRQ_STAT: rd_mux = stat_q;
         CAT_ADDR_IRQ_MASK: rd_mux = mask_q;
         default: rd_mux = 8'h00;
      endcase
   end

   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         rdata_q <= 8'h00;
      end else begin
         rdata_q <= i_bus.rd ? rd_mux : 8'h00;
      end
   end

   // Outputs
   assign o_rdata = rdata_q;
   assign o_count_value = cnt_q;
   assign o_rollover = rollover;
   assign o_module4_watchdog_en = mode_q[CAT_MODE_WDT_BIT];
   assign o_port1_claim = {i_module_pin_used, (src == CAT_SRC_EXT), 2'b00};
   assign o_vector_irq = (ctrl_q[CAT_CTRL_OVF_BIT] && mode_q[CAT_MODE_OVFIE_BIT])
      || |(ctrl_q[4:0] & i_module_irq_en);
   assign o_irq = |(stat_q & mask_q);

   // Helper: cycles since last prescale tick and whether ratio held
   logic [3:0] gap_q;
   logic [3:0] div_q;
   logic cfg_held_q;

   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         gap_q <= 4'h0;
         div_q <= CAT_DIV_SLOW;
         cfg_held_q <= 1'b0;
      end else begin
         gap_q <= psc_tick ? 4'h0 : gap_q + 4'h1;
         div_q <= div;
         // A ratio change voids the interval it falls in
         if (div != div_q) begin
            cfg_held_q <= 1'b0;
         end else if (psc_tick) begin
            cfg_held_q <= 1'b1;
         end
      end
   end

   sequence s_wrap;
      rollover ##1 (cnt_q == CAT_CNT_RST);
   endsequence

   sequence s_clear_race;
      wr_ctrl && !i_bus.wdata[0] && i_module_event[0];
   endsequence

   // Assertions
   ovf_flag_set_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
      rollover |=> ctrl_q[CAT_CTRL_OVF_BIT])
      else $error("overflow flag not set after rollover");

   wrap_zero_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
      rollover |-> s_wrap)
      else $error("counter did not wrap to zero");

   run_stop_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
      !ctrl_q[CAT_CTRL_RUN_BIT] |=> cnt_q == $past(cnt_q))
      else $error("counter moved while stopped");

   idle_gate_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
      (mode_q[CAT_MODE_IDLE_BIT] && i_cpu_idle) |=> cnt_q == $past(cnt_q))
      else $error("counter moved during gated idle");

   presc_ratio_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
      (psc_tick && cfg_held_q && (div == div_q) && (src == CAT_SRC_SLOW || src == CAT_SRC_FAST))
      |-> gap_q == div - 4'h1)
      else $error("internal count rate wrong");

   timer0_step_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
      (src == CAT_SRC_T0 && count_en && i_timer0_ovf) |=> cnt_q == $past(cnt_q) + 16'h0001)
      else $error("timer 0 overflow not counted");

   ext_edge_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
      (src == CAT_SRC_EXT && count_en && $fell(ext_s2_q))
      |=> cnt_q == $past(cnt_q) + 16'h0001 ##1 cnt_q == $past(cnt_q))
      else $error("external edge not counted once");

   wdt_enable_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
      wr_mode |=> o_module4_watchdog_en == $past(i_bus.wdata[CAT_MODE_WDT_BIT]))
      else $error("watchdog enable not following write");

   ovf_irq_gate_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
      (!mode_q[CAT_MODE_OVFIE_BIT] && (ctrl_q[4:0] & i_module_irq_en) == 5'h00)
      |-> !o_vector_irq)
      else $error("interrupt without enabled source");

   mod_irq_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
      (ctrl_q[0] && i_module_irq_en[0]) |-> o_vector_irq)
      else $error("module event raised no interrupt");

   flag_sticky_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
      (ctrl_q[0] && !wr_ctrl) |=> ctrl_q[0])
      else $error("module flag cleared without write");

   set_wins_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
      s_clear_race |=> ctrl_q[0])
      else $error("event lost against clear");

   ovf_hold_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
      (ctrl_q[CAT_CTRL_OVF_BIT] && !wr_ctrl) |=> ctrl_q[CAT_CTRL_OVF_BIT])
      else $error("overflow flag cleared by hardware");

   // Register, counter and interrupt invariants
   ovf_sw_set_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
      (wr_ctrl && i_bus.wdata[CAT_CTRL_OVF_BIT]) |=> ctrl_q[CAT_CTRL_OVF_BIT])
      else $error("overflow flag not set by software");

   mod4_flag_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
      i_module_event[4] |=> ctrl_q[4])
      else $error("module 4 flag not set by event");

   stat_wins_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
      (wr_stat && i_bus.wdata[0] && i_module_event[0]) |=> stat_q[0])
      else $error("status event lost against clear");

   step_inc_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
      step |=> cnt_q == $past(cnt_q) + 16'h0001)
      else $error("counter did not step by one");

   count_hold_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
      !step |=> cnt_q == $past(cnt_q))
      else $error("counter moved without a pulse");

   reserved_zero_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
      ((ctrl_q & ~CAT_CTRL_MASK) == 8'h00) && ((mode_q & ~CAT_MODE_MASK) == 8'h00))
      else $error("reserved register bit set");

   rdata_idle_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
      !i_bus.rd |=> o_rdata == 8'h00)
      else $error("read data outside read cycle");

   ovf_irq_on_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
      (ctrl_q[CAT_CTRL_OVF_BIT] && mode_q[CAT_MODE_OVFIE_BIT]) |-> o_vector_irq)
      else $error("enabled overflow raised no interrupt");

   stat_irq_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
      (stat_q[CAT_CTRL_OVF_BIT] && mask_q[CAT_CTRL_OVF_BIT]) |-> o_irq)
      else $error("unmasked rollover raised no interrupt");

   wdt_hold_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
      !wr_mode |=> $stable(o_module4_watchdog_en))
      else $error("watchdog enable changed without write");

endmodule : cat_timebase

`default_nettype wire

// [hw/cat_pkg.sv]
// Constants, types and shared helpers for the counter_array time base.
// Assumes one 100 MHz oscillator clock and an 8-bit special function bus.
`default_nettype none

package cat_pkg;

   // Register addresses
   localparam logic [7:0] CAT_ADDR_CTRL = 8'hd8;
   localparam logic [7:0] CAT_ADDR_MODE = 8'hd9;
   localparam logic [7:0] CAT_ADDR_CNT_LO = 8'he9;
   localparam logic [7:0] CAT_ADDR_CNT_HI = 8'hf9;
   localparam logic [7:0] CAT_ADDR_IRQ_STAT = 8'hd6;
   localparam logic [7:0] CAT_ADDR_IRQ_MASK = 8'hd7;

   // Field positions
   localparam int unsigned CAT_CTRL_OVF_BIT = 7;
   localparam int unsigned CAT_CTRL_RUN_BIT = 6;
   localparam int unsigned CAT_MODE_IDLE_BIT = 7;
   localparam int unsigned CAT_MODE_WDT_BIT = 6;
   localparam int unsigned CAT_MODE_SRC_HI = 2;
   localparam int unsigned CAT_MODE_SRC_LO = 1;
   localparam int unsigned CAT_MODE_OVFIE_BIT = 0;
   localparam int unsigned CAT_NUM_MODULES = 5;
   localparam int unsigned CAT_P1_EXT_BIT = 2;
   localparam int unsigned CAT_P1_MOD_LSB = 3;

   // Implemented-bit masks and reset values
   localparam logic [7:0] CAT_CTRL_MASK = 8'hdf;
   localparam logic [7:0] CAT_MODE_MASK = 8'hc7;
   localparam logic [7:0] CAT_IRQ_BITS = 8'h9f;
   localparam logic [7:0] CAT_CTRL_RST = 8'h00;
   localparam logic [7:0] CAT_MODE_RST = 8'h00;
   localparam logic [15:0] CAT_CNT_RST = 16'h0000;
   localparam logic [15:0] CAT_CNT_MAX = 16'hffff;

   // Oscillator dividers for the internal count sources
   localparam logic [3:0] CAT_DIV_SLOW = 4'hc;
   localparam logic [3:0] CAT_DIV_SLOW_DBL = 4'h6;
   localparam logic [3:0] CAT_DIV_FAST = 4'h4;
   localparam logic [3:0] CAT_DIV_FAST_DBL = 4'h2;
   // Fastest legal external count rate, in oscillator periods
   localparam int unsigned CAT_EXT_MIN_PERIOD = 8;

   typedef enum logic [1:0] {
      CAT_SRC_SLOW = 2'b00,
      CAT_SRC_FAST = 2'b01,
      CAT_SRC_T0 = 2'b10,
      CAT_SRC_EXT = 2'b11
   } cat_src_t;

   // Register bus request
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } cat_bus_t;

   // Prescale ratio for a source and speed mode
   function automatic logic [3:0] cat_div(input cat_src_t src, input logic dbl);
      if (src == CAT_SRC_SLOW) begin
         return dbl ? CAT_DIV_SLOW_DBL : CAT_DIV_SLOW;
      end
      return dbl ? CAT_DIV_FAST_DBL : CAT_DIV_FAST;
   endfunction : cat_div

endpackage : cat_pkg

`default_nettype wire

// [test/cat_timebase_test.sv]
// Self-checking bench for the counter_array time base core.
// Assumes cat_pkg and cat_timebase are compiled first; one 100 MHz clock.
`default_nettype none

module cat_timebase_test import cat_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;

   logic mclk, rstn, dbl, idle, t0, ext, rd_p, vec_irq, irq, roll, wdt;
   cat_bus_t bus;
   logic [4:0] mev, mien, mused;
   logic [7:0] rdata, claim, v;
   logic [15:0] cnt;
   logic [7:0] exp_q[$];
   int failures, total_checks, rolls, exp;
   int seed = 32'hab0a;

   cat_timebase DUT (.i_mclk(mclk), .i_rstn(rstn), .i_bus(bus), .o_rdata(rdata),
      .i_double_speed_mode(dbl), .i_cpu_idle(idle), .i_timer0_ovf(t0),
      .i_ext_count_input(ext), .i_module_event(mev), .i_module_irq_en(mien),
      .i_module_pin_used(mused), .o_count_value(cnt), .o_rollover(roll),
      .o_module4_watchdog_en(wdt), .o_port1_claim(claim), .o_vector_irq(vec_irq),
      .o_irq(irq));

   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] e);
      total_checks++;
      if (seen !== e) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", nm, e, seen);
      end
   endtask : chk

   task automatic tally_and_finish;
      if (failures == 0 && total_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : tally_and_finish

   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
   endtask : cyc

   // Bus cycles: one-cycle strobes, read expectation noted in the queue
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      bus <= '{1'b1, 1'b0, a, d};
      @(posedge mclk);
      bus <= '0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge mclk);
      bus <= '{1'b0, 1'b1, a, 8'h00};
      exp_q.push_back(e);
      @(posedge mclk);
      bus <= '0;
   endtask : rd

   task automatic do_reset;
      @(posedge mclk);
      rstn <= 1'b0;
      cyc(3);
      rstn <= 1'b1;
   endtask : do_reset

   task automatic pulse_t0(input int n);
      repeat (n) begin
         @(posedge mclk);
         t0 <= 1'b1;
         @(posedge mclk);
         t0 <= 1'b0;
      end
   endtask : pulse_t0

   task automatic lv(input logic ev, input logic ei);
      @(negedge mclk);
      chk("vector_irq", vec_irq, ev);
      chk("irq", irq, ei);
   endtask : lv

   // Cycles between counter steps, measured after the first two steps
   task automatic per(input int e);
      logic [15:0] c;
      int k;
      for (int j = 0; j < 3; j++) begin
         @(negedge mclk);
         c = cnt;
         k = 0;
         while (cnt === c && k < 50) begin
            @(negedge mclk);
            k++;
         end
      end
      chk("period", 16'(k + 1), 16'(e));
   endtask : per

   // Clock
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   // Read data stands only in the cycle after the strobe
   always @(posedge mclk) rd_p <= bus.rd;
   always @(negedge mclk) begin
      if (rd_p === 1'b1) chk("rdata", {8'h00, rdata}, {8'h00, exp_q.pop_front()});
      if (roll === 1'b1) rolls++;
   end

   // Watchdog against a hang
   initial begin
      cyc(90000);
      failures++;
      tally_and_finish();
   end

   // Main sequence
   initial begin
      rstn = 1'b0;
      bus = '0;
      {dbl, idle, t0, ext} = 4'h0;
      mev = '0;
      mien = '0;
      mused = '0;
      cyc(3);
      rstn <= 1'b1;
      rd(8'hd8, 8'h00);
      rd(8'hd9, 8'h00);
      rd(8'he9, 8'h00);
      rd(8'hf9, 8'h00);
      wr(8'h55, 8'hff);
      rd(8'h55, 8'h00);
      repeat (3) begin
         v = 8'($random(seed));
         wr(8'hd9, v);
         rd(8'hd9, v & CAT_MODE_MASK);
         chk("watchdog_en", wdt, v[6]);
      end
      wr(8'hd8, 8'h40);
      for (int c = 0; c < 4; c++) begin
         @(posedge mclk);
         dbl <= c[0];
         wr(8'hd9, c[1] ? 8'h02 : 8'h00);
         exp = c[1] ? (c[0] ? 2 : 4) : (c[0] ? 6 : 12);
         per(exp);
      end
      // Timer 0 source with idle gating and run control
      do_reset();
      dbl <= 1'b0;
      wr(8'hd9, 8'h84);
      wr(8'hd8, 8'h40);
      idle <= 1'b1;
      pulse_t0(3);
      idle <= 1'b0;
      pulse_t0(2);
      wr(8'hd9, 8'h04);
      idle <= 1'b1;
      pulse_t0(3);
      wr(8'hd8, 8'h00);
      pulse_t0(2);
      idle <= 1'b0;
      rd(8'he9, 8'h05);
      // External source, falling edges at the fastest legal rate
      do_reset();
      mused <= 5'($random(seed));
      wr(8'hd9, 8'h06);
      wr(8'hd8, 8'h40);
      repeat (5) begin
         ext <= 1'b1;
         cyc(4);
         ext <= 1'b0;
         cyc(4);
      end
      cyc(6);
      rd(8'he9, 8'h05);
      chk("port1_claim", claim, {mused, 3'b100});
      chk("count_value", cnt, 16'h0005);
      // Full wrap of the counter
      do_reset();
      wr(8'hd9, 8'h05);
      wr(8'hd7, 8'h80);
      wr(8'hd8, 8'h40);
      @(posedge mclk);
      t0 <= 1'b1;
      cyc(65536);
      t0 <= 1'b0;
      cyc(2);
      chk("rollovers", 16'(rolls), 16'h0001);
      rd(8'he9, 8'h00);
      rd(8'hf9, 8'h00);
      rd(8'hd8, 8'hc0);
      rd(8'hd6, 8'h80);
      lv(1'b1, 1'b1);
      wr(8'hd6, 8'h80);
      lv(1'b1, 1'b0);
      wr(8'hd9, 8'h04);
      lv(1'b0, 1'b0);
      wr(8'hd9, 8'h05);
      wr(8'hd8, 8'h40);
      lv(1'b0, 1'b0);
      wr(8'hd8, 8'hc0);
      rd(8'hd8, 8'hc0);
      // Module event flags and their enables
      do_reset();
      wr(8'hd7, 8'h1f);
      for (int n = 0; n < 5; n++) begin
         @(posedge mclk);
         mien <= 5'h00;
         mev <= 5'(1 << n);
         @(posedge mclk);
         mev <= 5'h00;
         lv(1'b0, 1'b1);
         @(posedge mclk);
         mien <= 5'(1 << n);
         lv(1'b1, 1'b1);
         rd(8'hd8, 8'(1 << n));
         rd(8'hd6, 8'(1 << n));
         wr(8'hd6, 8'(1 << n));
         wr(8'hd8, 8'h00);
         lv(1'b0, 1'b0);
      end
      rd(8'hd7, 8'h1f);
      // Event against a clearing write in the same cycle: the event wins
      fork
         wr(8'hd8, 8'h00);
         begin
            @(posedge mclk);
            mev <= 5'h01;
            @(posedge mclk);
            mev <= 5'h00;
         end
      join
      rd(8'hd8, 8'h01);
      fork
         wr(8'hd6, 8'h01);
         begin
            @(posedge mclk);
            mev <= 5'h01;
            @(posedge mclk);
            mev <= 5'h00;
         end
      join
      rd(8'hd6, 8'h01);
      tally_and_finish();
   end
endmodule : cat_timebase_test

`default_nettype wire
